// ### fcsp_host.sv
`timescale 1ns/1ps
module fcsp_host (
    output logic sclk,
    output logic cycle_gate_n,
    output logic data_in,
    input wire logic readback_out
);
    // ----------------------------------------
    // Host side of the serial link
    // ----------------------------------------
    // Link clock stands still low between frames
    initial begin
        sclk = 1'b0;
        cycle_gate_n = 1'b0;
        data_in = 1'b0;
        // A real rise clears the link counter, mode and readback bit; they have no other reset
        #1 cycle_gate_n = 1'b1;
    end

    // Mode bit then n bits, LSB first; n below five cuts a write short
    task automatic frame(input logic wr, input logic [4:0] bits, input int n,
            output logic [4:0] got);
        got = 5'h00;
        cycle_gate_n = 1'b0;
        for (int i = 0; i <= n; i++) begin
            data_in = (i == 0) ? wr : bits[i-1];
            #2;
            if (i > 0) begin
                got[i-1] = readback_out;
            end
            #1 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
        #3 cycle_gate_n = 1'b1;
        // Released line shows no stale value
        data_in = ~data_in;
    endtask
endmodule

// ### fcsp_pkg.sv
package fcsp_pkg;

    // ------------------------------------------------------------
    // Code register
    // ------------------------------------------------------------
    localparam int CODE_W = 5;
    localparam logic [4:0] CODE_RESET = 5'h00;
    localparam logic [4:0] CODE_SAT = 5'h1D;
    localparam logic [4:0] MHZ_MAX = 5'h1E;
    localparam logic [4:0] MHZ_STEP = 5'h01;
    localparam logic [4:0] MHZ_RESET = 5'h01;

    // ------------------------------------------------------------
    // Serial frame counts and synchronizer depth
    // ------------------------------------------------------------
    localparam int CNT_W = 3;
    localparam logic [2:0] CNT_IDLE = 3'h0;
    localparam logic [2:0] CNT_FIRST = 3'h1;
    localparam logic [2:0] CNT_LAST = 3'h5;
    localparam logic [2:0] CNT_DONE = 3'h6;
    localparam int SYNC_STAGES = 2;

endpackage

// ### fcsp_sync.sv
`timescale 1ns/1ps
module fcsp_sync (
    input wire logic clock,
    input wire logic srst,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } fcsp_sync_type;

    fcsp_sync_type st_q;
    fcsp_sync_type st_d;

    // Meta stage feeds only the stable stage
    always_comb begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '{meta: 1'b1, stable: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;
endmodule

// ### fcsp_top.sv
`timescale 1ns/1ps
module fcsp_top (
    input wire logic clock,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cycle_gate_n,
    input wire logic data_in,
    output logic readback_out,
    output logic [fcsp_pkg::CODE_W-1:0] corner_code,
    output logic [fcsp_pkg::CODE_W-1:0] corner_mhz
);
    import fcsp_pkg::*;

    // ------------------------------------------------------------
    // Link domain: frame control, cleared while the gate is high
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic is_read;
    } fcsp_ctl_type;

    typedef struct packed {
        logic [CODE_W-1:0] wr_shift;
        logic wr_full;
        logic [CODE_W-1:0] rd_shift;
    } fcsp_hold_type;

    fcsp_ctl_type ctl_q;
    fcsp_ctl_type ctl_d;
    fcsp_hold_type hold_q;
    fcsp_hold_type hold_d;
    logic rd_bit_q;
    logic [CODE_W-1:0] rd_sel;
    logic [CODE_W-1:0] code_q_w;

    always_comb begin
        ctl_d = ctl_q;
        hold_d = hold_q;
        if (ctl_q.cnt == CNT_IDLE) begin
            ctl_d.is_read = ~data_in;
            ctl_d.cnt = CNT_FIRST;
            hold_d.wr_full = 1'b0;
            // Code is quiet here: it moves only after the gate rises
            hold_d.rd_shift = code_q_w;
        end else if (ctl_q.cnt != CNT_DONE) begin
            ctl_d.cnt = ctl_q.cnt + CNT_FIRST;
            if (!ctl_q.is_read) begin
                hold_d.wr_shift = {data_in, hold_q.wr_shift[CODE_W-1:1]};
                hold_d.wr_full = (ctl_q.cnt == CNT_LAST);
            end
        end
    end

    // Gate high holds the counter idle; stray clocks still clear wr_full and reload rd_shift
    always_ff @(posedge sclk or posedge cycle_gate_n) begin
        if (cycle_gate_n) begin
            ctl_q <= '{cnt: CNT_IDLE, is_read: 1'b0};
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // Captured bits must outlive the frame; the link clock stops after it
    always_ff @(posedge sclk) begin
        hold_q <= hold_d;
    end

    // ------------------------------------------------------------
    // Link domain: readback on falling edges
    // ------------------------------------------------------------
    assign rd_sel = hold_q.rd_shift >> (ctl_q.cnt - CNT_FIRST);

    always_ff @(negedge sclk or posedge cycle_gate_n) begin
        if (cycle_gate_n) begin
            rd_bit_q <= 1'b0;
        end else if (ctl_q.is_read && ctl_q.cnt >= CNT_FIRST && ctl_q.cnt <= CNT_LAST) begin
            rd_bit_q <= rd_sel[0];
        end else begin
            rd_bit_q <= 1'b0;
        end
    end

    assign readback_out = rd_bit_q;

    // ------------------------------------------------------------
    // System domain: gate and write-complete crossings
    // ------------------------------------------------------------
    logic gate_s;
    logic full_s;

    fcsp_sync u_sync_gate (
        .clock(clock),
        .srst(srst),
        .async_in(cycle_gate_n),
        .sync_out(gate_s)
    );

    fcsp_sync u_sync_full (
        .clock(clock),
        .srst(srst),
        .async_in(hold_q.wr_full),
        .sync_out(full_s)
    );

    // ------------------------------------------------------------
    // System domain: code register and corner lookup
    // ------------------------------------------------------------
    typedef struct packed {
        logic gate_prev;
        logic [CODE_W-1:0] code;
        logic [CODE_W-1:0] mhz;
    } fcsp_sys_type;

    fcsp_sys_type sys_q;
    fcsp_sys_type sys_d;
    logic gate_rise;

    assign gate_rise = gate_s & ~sys_q.gate_prev;

    always_comb begin
        sys_d = sys_q;
        sys_d.gate_prev = gate_s;
        // Link data is frozen once the gate is high, so a plain copy is safe
        if (gate_rise && full_s) begin
            sys_d.code = hold_q.wr_shift;
        end
        if (sys_d.code > CODE_SAT) begin
            sys_d.mhz = MHZ_MAX;
        end else begin
            sys_d.mhz = sys_d.code + MHZ_STEP;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sys_q <= '{gate_prev: 1'b1, code: CODE_RESET, mhz: MHZ_RESET};
        end else begin
            sys_q <= sys_d;
        end
    end

    assign code_q_w = sys_q.code;
    // One register drives both corner outputs, code and frequency
    assign corner_code = sys_q.code;
    assign corner_mhz = sys_q.mhz;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_code_at_rise: assert property (
        @(posedge clock) disable iff (srst)
        (sys_q.code != $past(sys_q.code)) |-> $past(gate_rise && full_s))
    else $error("code changed without a gate rise");

    a_mhz_tracks_code: assert property (
        @(posedge clock) disable iff (srst)
        corner_mhz == ((corner_code > CODE_SAT) ? MHZ_MAX : corner_code + MHZ_STEP))
    else $error("corner frequency does not match code");

    a_mhz_in_range: assert property (
        @(posedge clock) disable iff (srst)
        corner_mhz >= MHZ_STEP && corner_mhz <= MHZ_MAX)
    else $error("corner frequency out of range");

    a_short_write_kept: assert property (
        @(posedge clock) disable iff (srst)
        (gate_rise && !full_s) |=> $stable(sys_q.code))
    else $error("short write altered the code");

    a_write_applied: assert property (
        @(posedge clock) disable iff (srst)
        (gate_rise && full_s) |=> (corner_code == $past(hold_q.wr_shift)))
    else $error("completed write not applied");

    a_gate_low_hold: assert property (
        @(posedge clock) disable iff (srst)
        (!gate_s && !$past(gate_s)) |-> $stable(corner_code))
    else $error("code moved while gate low");

    a_cnt_bounded: assert property (
        @(posedge sclk) disable iff (cycle_gate_n)
        ctl_q.cnt <= CNT_DONE)
    else $error("bit counter overran");

    a_write_full_fifth: assert property (
        @(posedge sclk) disable iff (cycle_gate_n)
        (!ctl_q.is_read && ctl_q.cnt == CNT_LAST) |=> hold_q.wr_full)
    else $error("fifth write bit did not complete");

    a_read_no_write: assert property (
        @(posedge sclk) disable iff (cycle_gate_n)
        (ctl_q.is_read && ctl_q.cnt != CNT_IDLE) |=> $stable(hold_q.wr_shift))
    else $error("read frame disturbed write shift");

    a_read_bit_value: assert property (
        @(negedge sclk) disable iff (cycle_gate_n)
        (ctl_q.is_read && ctl_q.cnt == CNT_FIRST) |=> (readback_out == hold_q.rd_shift[0]))
    else $error("first readback bit wrong");

    a_read_bits_lsb: assert property (
        @(negedge sclk) disable iff (cycle_gate_n)
        (ctl_q.is_read && ctl_q.cnt >= CNT_FIRST && ctl_q.cnt <= CNT_LAST)
            |=> (readback_out == hold_q.rd_shift[$past(ctl_q.cnt) - CNT_FIRST]))
    else $error("readback bit out of order");

    a_full_cleared: assert property (
        @(posedge sclk) disable iff (cycle_gate_n)
        (ctl_q.cnt == CNT_IDLE) |=> !hold_q.wr_full)
    else $error("write completion not cleared at frame start");

    a_mode_latched: assert property (
        @(posedge sclk) disable iff (cycle_gate_n)
        (ctl_q.cnt == CNT_IDLE) |=> (ctl_q.is_read == !$past(data_in)))
    else $error("frame mode not taken from first bit");
endmodule

// ### test_filter_corner_serial_port.sv
`timescale 1ns/1ps
module test_filter_corner_serial_port;
    import fcsp_pkg::*;
    logic clock;
    logic srst;
    logic sclk;
    logic cycle_gate_n;
    logic data_in;
    logic readback_out;
    logic [CODE_W-1:0] corner_code;
    logic [CODE_W-1:0] corner_mhz;
    logic [4:0] model = 5'h00;
    int err_count = 0;
    int n_compared = 0;

    fcsp_top fcsp_top_i (.clock(clock), .srst(srst), .sclk(sclk),
        .cycle_gate_n(cycle_gate_n), .data_in(data_in), .readback_out(readback_out),
        .corner_code(corner_code), .corner_mhz(corner_mhz));
    fcsp_host fcsp_host_i (.sclk(sclk), .cycle_gate_n(cycle_gate_n),
        .data_in(data_in), .readback_out(readback_out));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Code must not move until the gate rise has crossed over
    task automatic t_write(input logic [4:0] code, input logic [4:0] mhz);
        logic [4:0] got;
        @(negedge clock);
        fcsp_host_i.frame(1'b1, code, 5, got);
        @(negedge clock);
        chk("code before apply", model, corner_code);
        repeat (5) @(negedge clock);
        model = code;
        chk("code", model, corner_code);
        chk("mhz", mhz, corner_mhz);
    endtask

    task automatic t_read();
        logic [4:0] got;
        @(negedge clock);
        fcsp_host_i.frame(1'b0, ~model, 5, got);
        chk("readback", model, got);
        #1 chk("idle out", 5'h00, {4'h0, readback_out});
        repeat (6) @(negedge clock);
        chk("code after read", model, corner_code);
    endtask

    task automatic t_short();
        logic [4:0] got;
        @(negedge clock);
        fcsp_host_i.frame(1'b1, ~model, 3, got);
        repeat (6) @(negedge clock);
        chk("code after cut", model, corner_code);
    endtask

    // Mid-run reset with the link idle
    task automatic t_reset();
        @(negedge clock);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        model = CODE_RESET;
        chk("reset code again", model, corner_code);
        chk("reset mhz again", MHZ_RESET, corner_mhz);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        chk("reset code", CODE_RESET, corner_code);
        chk("reset mhz", MHZ_RESET, corner_mhz);
        t_write(5'h0A, 5'h0B);
        t_read();
        t_write(5'h1D, 5'h1E);
        t_write(5'h1E, 5'h1E);
        t_write(5'h1F, 5'h1E);
        t_read();
        t_short();
        t_write(5'h00, 5'h01);
        t_write(5'h15, 5'h16);
        t_read();
        t_reset();
        t_read();
        summarize();
    end

    // Hang guard
    initial begin
        #100000;
        $display("ERROR watchdog expected done seen hang");
        err_count++;
        summarize();
    end
endmodule
